//--- core/lchm_pkg.sv
// Package with constants shared by the limit checker and its channel slices.
package lchm_pkg;
    localparam int NCH = 9;
    localparam int DW = 12;
    localparam int FIRST_TEMP = 6;
    localparam int DIODE_CH = 2;
    localparam int OPEN_BIT = 11;
    localparam logic [11:0] LIM_MAX = 12'hfff;
    localparam logic [11:0] LIM_MIN = 12'h000;
    localparam logic [11:0] HYST_RST = 12'h008;
    localparam logic [11:0] HYST_RST_TEMP = 12'h020;
    localparam logic [11:0] HYST_REC = 12'hfff;
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_ST_A = 8'h04;
    localparam logic [7:0] OFS_ST_B = 8'h08;
    localparam logic [7:0] OFS_ST_C = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_RESULT = 8'h14;
    localparam logic [3:0] CH_BLOCK_FIRST = 4'h4;
    localparam logic [1:0] SUB_UPPER = 2'h0;
    localparam logic [1:0] SUB_LOWER = 2'h1;
    localparam logic [1:0] SUB_HYST = 2'h2;
    localparam int CFG_PIN = 0;
    localparam int CFG_FLAG = 1;
    localparam int CFG_AUTO = 2;
    localparam logic [2:0] CFG_RST = 3'h3;
    localparam int STW = 24;
    localparam int ST_OR1 = 12;
    localparam int ST_OR2 = 13;
    localparam int ST_OTEMP = 22;
    localparam int ST_OPEN = 23;
    localparam logic [23:0] MASK_RST = 24'hffffff;
    localparam int AUTO_NS = 50000;
    localparam int CLK_NS = 8;
    localparam int AUTO_CYC = AUTO_NS / CLK_NS;
endpackage

//--- core/lchm_chan_if.sv
// Interface between the limit checker core and one channel slice.
`timescale 1ns/1ps
`default_nettype none
interface lchm_chan_if;
    logic wr_up;
    logic wr_lo;
    logic wr_hy;
    logic [11:0] wdata;
    logic cv;
    logic [11:0] cdata;
    logic [11:0] up;
    logic [11:0] lo;
    logic [11:0] hy;
    logic set_hi;
    logic set_lo;
    logic clr_hi;
    logic clr_lo;
    modport ctl (output wr_up, wr_lo, wr_hy, wdata, cv, cdata,
                 input up, lo, hy, set_hi, set_lo, clr_hi, clr_lo);
    modport chan (input wr_up, wr_lo, wr_hy, wdata, cv, cdata,
                  output up, lo, hy, set_hi, set_lo, clr_hi, clr_lo);
endinterface
`default_nettype wire

//--- core/lchm_limit_chan.sv
// One channel slice: limits, hysteresis and min/max recorder.
`timescale 1ns/1ps
`default_nettype none
module lchm_limit_chan #(
    parameter bit TEMP = 1'b0
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    lchm_chan_if.chan ch
);
    typedef struct packed {
        logic [11:0] up;
        logic [11:0] lo;
        logic [11:0] hy;
    } lchm_chan_st_t;

    lchm_chan_st_t s_r;
    lchm_chan_st_t s_nxt;
    logic rec;
    logic over;
    logic under;
    logic back_hi;
    logic back_lo;

    always_comb begin
        s_nxt = s_r;
        rec = (s_r.hy == lchm_pkg::HYST_REC); // R13
        over = ch.cdata > s_r.up; // R1
        under = ch.cdata < s_r.lo; // R2
        // Thirteen-bit sums keep large hysteresis codes from wrapping, so an alert clears only with the result a full hy inside the limit.
        back_hi = ({1'b0, ch.cdata} + {1'b0, s_r.hy}) <= {1'b0, s_r.up}; // R7 R9
        back_lo = {1'b0, ch.cdata} >= ({1'b0, s_r.lo} + {1'b0, s_r.hy}); // R7 R9
        if (ch.cv && rec) begin
            if (over) begin
                s_nxt.up = ch.cdata; // R16
            end
            if (under) begin
                s_nxt.lo = ch.cdata; // R16
            end
        end
        if (ch.wr_up) begin
            s_nxt.up = ch.wdata;
        end
        if (ch.wr_lo) begin
            s_nxt.lo = ch.wdata;
        end
        if (ch.wr_hy) begin
            s_nxt.hy = ch.wdata; // R8
        end
    end

    assign ch.set_hi = ch.cv && !rec && over;
    assign ch.set_lo = ch.cv && !rec && under;
    assign ch.clr_hi = ch.cv && !rec && !over && back_hi; // R4
    assign ch.clr_lo = ch.cv && !rec && !under && back_lo; // R4
    assign ch.up = s_r.up;
    assign ch.lo = s_r.lo;
    assign ch.hy = s_r.hy;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_r.up <= lchm_pkg::LIM_MAX; // R14
            s_r.lo <= lchm_pkg::LIM_MIN; // R14
            s_r.hy <= TEMP ? lchm_pkg::HYST_RST_TEMP : lchm_pkg::HYST_RST; // R12
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule // lchm_limit_chan
`default_nettype wire

//--- core/lchm_top.sv
// Limit checker with hysteresis and min/max recorder behind a Wishbone slave.
// Operation
// [R1] A result above a channel's upper limit raises that channel's high alert.
// [R2] A result below a channel's lower limit raises that channel's low alert.
// [R3] Alerts show on the alert pin, the result word flag, or both, per configuration.
// [R4] An alert clears itself when a later result for the channel is back inside the limits.
// [R5] Alert status is updated on every conversion, so it can clear before software reads it.
// [R6] In autocycle mode a conversion is requested about every 50 microseconds.
// [R7] With hysteresis the alert clears only N LSB inside the violated limit.
// [R8] N comes from the channel's own 12-bit hysteresis register.
// [R9] A hysteresis code near full scale stops limit alerts from clearing by themselves.
// [R10] Bit 11 of a diode channel's limit registers reads 0 when the diode is open.
// [R11] Overrange alerts stay set until software clears them.
// [R12] Hysteresis resets to 8 LSB, or 32 LSB on temperature channels.
// [R13] A hysteresis code of all ones turns the limit registers into min/max stores.
// [R14] Upper limits reset to full code and lower limits to zero.
// [R15] Writing ones to an alert status register clears those bits.
// [R16] In recorder mode new extremes replace the stored maximum or minimum, with no alert.
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module lchm_top #(
    parameter int AUTO_CYC = lchm_pkg::AUTO_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic conv_valid,
    input wire logic [3:0] conv_chan,
    input wire logic [11:0] conv_data,
    input wire logic current_overrange_output_1,
    input wire logic current_overrange_output_2,
    input wire logic [1:0] diode_open,
    input wire logic over_temp,
    output logic conv_req,
    output logic res_valid,
    output logic [16:0] res_word,
    output logic alert_pin,
    output logic irq
);
    localparam int NCH = lchm_pkg::NCH;
    localparam int CW = $clog2(AUTO_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(AUTO_CYC - 1);

    typedef struct packed {
        logic [2:0] cfg;
        logic [23:0] st;
        logic [23:0] mask;
        logic ack;
        logic [31:0] rdata;
        logic [CW-1:0] cnt;
        logic conv_req;
        logic res_valid;
        logic [16:0] res_word;
    } lchm_top_st_t;

    lchm_top_st_t s_r;
    lchm_top_st_t s_nxt;

    logic [11:0] up_a [NCH];
    logic [11:0] lo_a [NCH];
    logic [11:0] hy_a [NCH];
    logic [NCH-1:0] set_hi_a;
    logic [NCH-1:0] set_lo_a;
    logic [NCH-1:0] clr_hi_a;
    logic [NCH-1:0] clr_lo_a;

    logic req;
    logic wr_ev;
    logic [3:0] blk;
    logic [3:0] ch_idx;
    logic [1:0] sub;
    logic ch_hit;
    logic [11:0] ch_cur;
    logic [11:0] ch_wdata;
    logic [31:0] wmask;
    logic [23:0] set_v;
    logic [23:0] clr_v;
    logic [23:0] w1c;
    logic [23:0] lim_bits;

    lchm_chan_if ch_if [NCH] ();

    // Status bit of a channel's low alert; the high alert sits one above it.
    function automatic int st_pos(input int c);
        st_pos = (c >= lchm_pkg::FIRST_TEMP) ? 2 * c + 4 : 2 * c;
    endfunction

    assign req = wb_cyc_i && wb_stb_i;
    assign wr_ev = req && wb_we_i && s_r.ack;
    assign blk = wb_adr_i[7:4];
    assign sub = wb_adr_i[3:2];
    assign ch_idx = blk - lchm_pkg::CH_BLOCK_FIRST;
    assign ch_hit = (blk >= lchm_pkg::CH_BLOCK_FIRST) && (ch_idx < 4'(NCH))
        && (sub != 2'h3);
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign ch_wdata = (wb_dat_i[11:0] & wmask[11:0]) | (ch_cur & ~wmask[11:0]);

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_ch
            lchm_limit_chan #(
                .TEMP(g >= lchm_pkg::FIRST_TEMP)
            ) u_chan (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .ch(ch_if[g])
            );
            assign ch_if[g].cv = conv_valid && (conv_chan == 4'(g));
            assign ch_if[g].cdata = conv_data;
            assign ch_if[g].wdata = ch_wdata;
            assign ch_if[g].wr_up = wr_ev && ch_hit && (ch_idx == 4'(g))
                && (sub == lchm_pkg::SUB_UPPER);
            assign ch_if[g].wr_lo = wr_ev && ch_hit && (ch_idx == 4'(g))
                && (sub == lchm_pkg::SUB_LOWER);
            assign ch_if[g].wr_hy = wr_ev && ch_hit && (ch_idx == 4'(g))
                && (sub == lchm_pkg::SUB_HYST); // R8
            assign up_a[g] = ch_if[g].up;
            assign lo_a[g] = ch_if[g].lo;
            assign hy_a[g] = ch_if[g].hy;
            assign set_hi_a[g] = ch_if[g].set_hi;
            assign set_lo_a[g] = ch_if[g].set_lo;
            assign clr_hi_a[g] = ch_if[g].clr_hi;
            assign clr_lo_a[g] = ch_if[g].clr_lo;
        end
    endgenerate

    // Current value of the addressed channel register, with the diode flag on readback.
    always_comb begin
        ch_cur = 12'h000;
        for (int c = 0; c < NCH; c++) begin
            if (ch_idx == 4'(c)) begin
                case (sub)
                    lchm_pkg::SUB_UPPER: ch_cur = up_a[c];
                    lchm_pkg::SUB_LOWER: ch_cur = lo_a[c];
                    lchm_pkg::SUB_HYST: ch_cur = hy_a[c];
                    default: ch_cur = 12'h000;
                endcase
                if (c >= lchm_pkg::FIRST_TEMP && c < lchm_pkg::FIRST_TEMP + lchm_pkg::DIODE_CH
                    && sub != lchm_pkg::SUB_HYST) begin
                    ch_cur[lchm_pkg::OPEN_BIT] = !diode_open[c - lchm_pkg::FIRST_TEMP]; // R10
                end
            end
        end
    end

    // Status events and clears gathered into the 24-bit status vector.
    always_comb begin
        set_v = 24'h000000;
        clr_v = 24'h000000;
        lim_bits = 24'h000000;
        for (int c = 0; c < NCH; c++) begin
            set_v[st_pos(c)] = set_lo_a[c]; // R2
            set_v[st_pos(c) + 1] = set_hi_a[c]; // R1
            clr_v[st_pos(c)] = clr_lo_a[c]; // R4 R5
            clr_v[st_pos(c) + 1] = clr_hi_a[c]; // R4 R5
            lim_bits[st_pos(c)] = 1'b1;
            lim_bits[st_pos(c) + 1] = 1'b1;
        end
        // Overrange, overtemperature and open diode bits never clear automatically.
        set_v[lchm_pkg::ST_OR1] = current_overrange_output_1; // R11
        set_v[lchm_pkg::ST_OR2] = current_overrange_output_2; // R11
        set_v[lchm_pkg::ST_OTEMP] = over_temp;
        set_v[lchm_pkg::ST_OPEN] = |diode_open;
    end

    always_comb begin
        w1c = 24'h000000;
        if (wr_ev) begin
            case (wb_adr_i)
                lchm_pkg::OFS_ST_A: w1c[7:0] = wb_dat_i[7:0] & wmask[7:0]; // R15
                lchm_pkg::OFS_ST_B: w1c[15:8] = wb_dat_i[7:0] & wmask[7:0]; // R15
                lchm_pkg::OFS_ST_C: w1c[23:16] = wb_dat_i[7:0] & wmask[7:0]; // R15
                default: w1c = 24'h000000;
            endcase
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = req && !s_r.ack;
        // A hardware set in the same cycle as a clear wins.
        s_nxt.st = set_v | (s_r.st & ~clr_v & ~w1c); // R5 R11 R15
        if (wr_ev) begin
            case (wb_adr_i)
                lchm_pkg::OFS_CFG: begin
                    s_nxt.cfg = (wb_dat_i[2:0] & wmask[2:0]) | (s_r.cfg & ~wmask[2:0]);
                end
                lchm_pkg::OFS_MASK: begin
                    s_nxt.mask = (wb_dat_i[23:0] & wmask[23:0]) | (s_r.mask & ~wmask[23:0]);
                end
                default: s_nxt.mask = s_r.mask;
            endcase
        end
        s_nxt.rdata = 32'h00000000;
        if (req && !s_r.ack && !wb_we_i) begin
            case (wb_adr_i)
                lchm_pkg::OFS_CFG: s_nxt.rdata[2:0] = s_r.cfg;
                lchm_pkg::OFS_ST_A: s_nxt.rdata[7:0] = s_r.st[7:0];
                lchm_pkg::OFS_ST_B: s_nxt.rdata[7:0] = s_r.st[15:8];
                lchm_pkg::OFS_ST_C: s_nxt.rdata[7:0] = s_r.st[23:16];
                lchm_pkg::OFS_MASK: s_nxt.rdata[23:0] = s_r.mask;
                lchm_pkg::OFS_RESULT: s_nxt.rdata[16:0] = s_r.res_word;
                default: s_nxt.rdata[11:0] = ch_hit ? ch_cur : 12'h000;
            endcase
        end
        // Autocycle trigger toward the conversion sequencer.
        s_nxt.conv_req = 1'b0;
        if (!s_r.cfg[lchm_pkg::CFG_AUTO]) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt == CNT_LAST) begin
            s_nxt.cnt = '0;
            s_nxt.conv_req = 1'b1; // R6
        end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
        s_nxt.res_valid = conv_valid;
        if (conv_valid) begin
            s_nxt.res_word = {s_r.cfg[lchm_pkg::CFG_FLAG] && |(s_nxt.st & lim_bits),
                              conv_chan, conv_data}; // R3
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_r.cfg <= lchm_pkg::CFG_RST;
            s_r.st <= 24'h000000;
            s_r.mask <= lchm_pkg::MASK_RST;
            s_r.ack <= 1'b0;
            s_r.rdata <= 32'h00000000;
            s_r.cnt <= '0;
            s_r.conv_req <= 1'b0;
            s_r.res_valid <= 1'b0;
            s_r.res_word <= 17'h00000;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.rdata;
    assign conv_req = s_r.conv_req;
    assign res_valid = s_r.res_valid;
    assign res_word = s_r.res_word;
    assign irq = |(s_r.st & s_r.mask);
    assign alert_pin = s_r.cfg[lchm_pkg::CFG_PIN] && irq; // R3
endmodule // lchm_top
`default_nettype wire

//--- tb/lchm_top_properties.sv
// Checker for the limit checker's bus, conversion and alert ports.
`timescale 1ns/1ps
`default_nettype none
module lchm_top_properties #(
    parameter int AUTO_CYC = 20
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic conv_valid,
    input wire logic [3:0] conv_chan,
    input wire logic [11:0] conv_data,
    input wire logic conv_req,
    input wire logic res_valid,
    input wire logic [16:0] res_word,
    input wire logic alert_pin,
    input wire logic irq
);
    logic [15:0] gap_r;
    logic seen_r;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Counts cycles since the last conversion request, saturating.
    always_ff @(posedge ref_clk) begin
        if (!reset_n || conv_req) begin
            gap_r <= 16'h0000;
        end else if (gap_r != 16'hffff) begin
            gap_r <= gap_r + 16'h0001;
        end
        seen_r <= reset_n && (seen_r || conv_req);
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_conv;
        conv_valid ##1 res_valid;
    endsequence
    a_ack_follows: assert property (s_req |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_res_follows: assert property (conv_valid |=> res_valid)
        else $error("result pulse missing");
    a_res_cause: assert property (res_valid |-> $past(conv_valid))
        else $error("result pulse without conversion");
    a_res_word: assert property (s_conv |->
        res_word[15:0] == {$past(conv_chan), $past(conv_data)})
        else $error("result word wrong");
    a_pin_gated: assert property (alert_pin |-> irq)
        else $error("alert pin without interrupt");
    a_req_gap: assert property (conv_req && seen_r |-> gap_r >= AUTO_CYC - 1)
        else $error("conversion requests too close");
    a_req_pulse: assert property (conv_req |=> !conv_req)
        else $error("conversion request longer than one cycle");
endmodule // lchm_top_properties
bind lchm_top lchm_top_properties #(.AUTO_CYC(AUTO_CYC)) u_props (
    .ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .conv_valid,
    .conv_chan, .conv_data, .conv_req, .res_valid, .res_word, .alert_pin, .irq
);
`default_nettype wire

//--- tb/lchm_seq_model.sv
// Model of the conversion sequencer that feeds results to the limit checker.
`timescale 1ns/1ps
`default_nettype none
module lchm_seq_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic conv_req,
    input wire logic go,
    input wire logic [3:0] go_chan,
    input wire logic [11:0] go_data,
    output logic conv_valid,
    output logic [3:0] conv_chan,
    output logic [11:0] conv_data
);
    logic [3:0] seq_r;
    // Outside a result the lines toggle so stale values are never trusted.
    always_ff @(posedge ref_clk) begin
        conv_valid <= reset_n && (go || conv_req);
        if (!reset_n) begin
            seq_r <= 4'h0;
            conv_chan <= 4'h0;
            conv_data <= 12'h000;
        end else if (go || conv_req) begin
            conv_chan <= go ? go_chan : seq_r;
            conv_data <= go ? go_data : 12'h400;
            seq_r <= (conv_req && seq_r != 4'h8) ? seq_r + 4'h1 : 4'h0;
        end else begin
            conv_chan <= ~conv_chan;
            conv_data <= ~conv_data;
        end
    end
endmodule // lchm_seq_model
`default_nettype wire

//--- tb/lchm_top_tb_top.sv
// Testbench for the limit checker: registers, limits, alerts and recorder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin \
    cmp_count++; \
    if ((s) !== (e)) begin \
        miscompares++; \
        $display("mismatch %s exp %0h got %0h", nm, e, s); \
    end \
end
module lchm_top_tb_top;
    localparam int AC = 20;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic current_overrange_output_1 = 1'b0;
    logic current_overrange_output_2 = 1'b0;
    logic [1:0] diode_open = 2'h0;
    logic over_temp = 1'b0;
    logic go = 1'b0;
    logic [3:0] go_chan = 4'h0;
    logic [11:0] go_data = 12'h000;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    logic wb_ack_o;
    logic conv_valid;
    logic [3:0] conv_chan;
    logic [11:0] conv_data;
    logic conv_req;
    logic res_valid;
    logic [16:0] res_word;
    logic alert_pin;
    logic irq;
    int miscompares = 0;
    int cmp_count = 0;
    lchm_top #(.AUTO_CYC(AC)) dut (
        .ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .conv_valid, .conv_chan, .conv_data, .current_overrange_output_1,
        .current_overrange_output_2, .diode_open, .over_temp, .conv_req, .res_valid,
        .res_word, .alert_pin, .irq
    );
    lchm_seq_model seq (
        .ref_clk, .reset_n, .conv_req, .go, .go_chan, .go_data, .conv_valid, .conv_chan,
        .conv_data
    );
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic complete_run();
        $display("compared %0d, mismatched %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            complete_run();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, q);
    endtask
    task automatic cv(input logic [3:0] c, input logic [11:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        go <= 1'b1;
        go_chan <= c;
        go_data <= d;
        @(posedge ref_clk);
        go <= 1'b0;
        while (res_valid !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (res_valid !== 1'b1) begin
            miscompares++;
            complete_run();
        end
    endtask
    task automatic t_defaults();
        rc(8'h00, 32'h3);
        rc(8'h40, 32'hfff);
        rc(8'h44, 32'h0);
        rc(8'h48, 32'h8);
        rc(8'ha8, 32'h20);
        rc(8'h4c, 32'h0);
        rc(8'h10, 32'hffffff);
        $display("defaults done");
    endtask
    task automatic t_limits();
        wb(1'b1, 8'h40, 32'h800);
        wb(1'b1, 8'h44, 32'h100);
        cv(4'h0, 12'h801);
        `CHK("flag", 1'b1, res_word[16]);
        `CHK("pin", 1'b1, alert_pin);
        rc(8'h04, 32'h2);
        cv(4'h0, 12'h7f9);
        rc(8'h04, 32'h2);
        cv(4'h0, 12'h7f8);
        `CHK("irq", 1'b0, irq);
        rc(8'h04, 32'h0);
        cv(4'h0, 12'h0ff);
        rc(8'h04, 32'h1);
        cv(4'h0, 12'h107);
        rc(8'h04, 32'h1);
        cv(4'h0, 12'h108);
        rc(8'h04, 32'h0);
        wb(1'b1, 8'h00, 32'h2);
        cv(4'h0, 12'h900);
        `CHK("pin", 1'b0, alert_pin);
        `CHK("flag", 1'b1, res_word[16]);
        wb(1'b1, 8'h00, 32'h1);
        cv(4'h0, 12'h901);
        `CHK("pin", 1'b1, alert_pin);
        `CHK("flag", 1'b0, res_word[16]);
        wb(1'b1, 8'h00, 32'h3);
        cv(4'h0, 12'h400);
        $display("limits done");
    endtask
    task automatic t_sticky();
        @(posedge ref_clk);
        current_overrange_output_1 <= 1'b1;
        current_overrange_output_2 <= 1'b1;
        @(posedge ref_clk);
        current_overrange_output_1 <= 1'b0;
        current_overrange_output_2 <= 1'b0;
        rc(8'h08, 32'h30);
        wb(1'b1, 8'h08, 32'h10);
        rc(8'h08, 32'h20);
        `CHK("irq", 1'b1, irq);
        wb(1'b1, 8'h10, 32'h0);
        @(posedge ref_clk);
        `CHK("irq", 1'b0, irq);
        wb(1'b1, 8'h10, 32'hffffff);
        wb(1'b1, 8'h08, 32'hff);
        rc(8'h08, 32'h0);
        $display("sticky done");
    endtask
    task automatic t_auto();
        int n;
        int m;
        n = 0;
        m = 0;
        wb(1'b1, 8'h00, 32'h7);
        while (conv_req !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK("req", 1'b1, conv_req);
        do begin
            @(posedge ref_clk);
            m++;
        end while (conv_req !== 1'b1 && m < 100);
        `CHK("gap", AC, m);
        wb(1'b1, 8'h00, 32'h3);
        $display("autocycle done");
    endtask
    task automatic t_recorder();
        wb(1'b1, 8'h58, 32'hfff);
        wb(1'b1, 8'h50, 32'h0);
        wb(1'b1, 8'h54, 32'hfff);
        cv(4'h1, 12'h300);
        cv(4'h1, 12'h500);
        cv(4'h1, 12'h200);
        rc(8'h50, 32'h500);
        rc(8'h54, 32'h200);
        rc(8'h04, 32'h0);
        $display("recorder done");
    endtask
    task automatic t_noclear();
        wb(1'b1, 8'h68, 32'h77d);
        wb(1'b1, 8'h60, 32'h100);
        cv(4'h2, 12'h101);
        cv(4'h2, 12'h000);
        rc(8'h04, 32'h20);
        rc(8'h48, 32'h8);
        wb_sel_i <= 4'h1;
        wb(1'b1, 8'h48, 32'hfff);
        wb_sel_i <= 4'hf;
        rc(8'h48, 32'hff);
        wb(1'b1, 8'h04, 32'hff);
        $display("no clear done");
    endtask
    task automatic t_diode();
        diode_open <= 2'h1;
        over_temp <= 1'b1;
        @(posedge ref_clk);
        rc(8'ha0, 32'h7ff);
        rc(8'hb0, 32'hfff);
        rc(8'h0c, 32'hc0);
        diode_open <= 2'h0;
        over_temp <= 1'b0;
        @(posedge ref_clk);
        wb(1'b1, 8'h0c, 32'hff);
        rc(8'h0c, 32'h0);
        rc(8'ha0, 32'hfff);
        $display("diode done");
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_defaults();
        t_limits();
        t_sticky();
        t_auto();
        t_recorder();
        t_noclear();
        t_diode();
        complete_run();
    end
endmodule // lchm_top_tb_top
`default_nettype wire
